// [verilog/pcs_rmii_defs.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef PCS_RMII_DEFS_SVH
`define PCS_RMII_DEFS_SVH
`define PCS_CFG_IDX      8'h16
`define RIB_IDX          8'h17
`define FREE_CLK_BIT     11
`define TQ_BIT           10
`define FSD_BIT          9
`define SDALG_BIT        8
`define DTS_BIT          7
`define F100_BIT         5
`define NRZI_BIT         2
`define RMODE_BIT        5
`define OLDREV_BIT       4
`define PCS_WMASK        16'h0fa4
`define PCS_RST          16'h0100
`define RIB_WMASK        16'h0030
`define RIB_RST          16'h0000
`define CLK_NS           50
`define DESC_SHORT_NS    722000
`define DESC_LONG_NS     2000000
`define STRAP_LOAD_CNT   2'h2
`define STRAP_DONE_CNT   2'h3
`endif

// [verilog/pcs_rmii_pkg.sv]
// Types shared by the coding sublayer configuration block
package pcs_rmii_pkg;
  typedef struct packed {
    logic true_quiet;
    logic force_sd;
    logic sd_alg;
    logic descrambler_timeout_select_sel;
    logic force_100_ok;
    logic nrzi_bypass;
  } pcs_ctrl_s;
  typedef enum logic {LINK_DOWN, LINK_UP} link_state_e;
endpackage

// [verilog/link_monitor.sv]
// Signal detect, descrambler lock timeout and link state machine
`timescale 1ns/10ps
`default_nettype none
`include "pcs_rmii_defs.svh"
module link_monitor
  import pcs_rmii_pkg::*;
#(
  parameter int SHORT_CYC = 14440,
  parameter int LONG_CYC  = 40000
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  // Control and receive status
  input  wire pcs_ctrl_s  ctrl,
  input  wire logic       signal_level,
  input  wire logic       descr_ok,
  // Status
  output logic            link_up_r,
  output logic            locked_r
);
  localparam logic [15:0] SHORT_T = 16'(SHORT_CYC - 1);
  localparam logic [15:0] LONG_T  = 16'(LONG_CYC - 1);
  link_state_e state_r;
  link_state_e state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] tmo;
  logic        sd;

  assign sd  = ctrl.force_sd | signal_level;
  assign tmo = ctrl.descrambler_timeout_select_sel ? LONG_T : SHORT_T;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r    <= 16'h0000;
      locked_r <= 1'b0;
    end else if (ce) begin
      if (descr_ok) begin
        cnt_r    <= 16'h0000;
        locked_r <= 1'b1;
      end else if (locked_r && cnt_r >= tmo) begin
        cnt_r    <= 16'h0000;
        locked_r <= 1'b0;
      end else if (locked_r) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LINK_DOWN: if (sd && locked_r) state_nxt = LINK_UP;
      LINK_UP: begin
        if (!sd) state_nxt = LINK_DOWN;
        else if (!ctrl.sd_alg && !locked_r) state_nxt = LINK_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r   <= LINK_DOWN;
      link_up_r <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      link_up_r <= (state_nxt == LINK_UP) | ctrl.force_100_ok;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_alg1_hold;
    ce && state_r == LINK_UP && sd && ctrl.sd_alg |=> state_r == LINK_UP;
  endproperty
  a_alg1_hold: assert property (p_alg1_hold)
    else $error("link dropped while signal valid");
  property p_alg0_drop;
    ce && state_r == LINK_UP && !locked_r && !ctrl.sd_alg
      |=> state_r == LINK_DOWN;
  endproperty
  a_alg0_drop: assert property (p_alg0_drop)
    else $error("link kept without lock");
  property p_force_ok;
    ce && ctrl.force_100_ok |=> link_up_r;
  endproperty
  a_force_ok: assert property (p_force_ok)
    else $error("forced link not shown");
  property p_timeout;
    ce && locked_r && !descr_ok && cnt_r >= tmo |=> !locked_r;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("lock not lost at timeout");
  c_link_up: cover property (ce && state_r == LINK_DOWN ##1 state_r == LINK_UP);
endmodule
`default_nettype wire

// [verilog/crs_dv_gen.sv]
// Reduced interface carrier/data valid generation and bypass
`timescale 1ns/10ps
`default_nettype none
module crs_dv_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Mode
  input  wire logic rmii_mode,
  input  wire logic old_rev,
  // Receive status
  input  wire logic crs,
  input  wire logic rx_dv,
  // Outputs
  output logic      crs_dv_r,
  output logic      mii_crs_r,
  output logic      mii_dv_r
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crs_dv_r  <= 1'b0;
      mii_crs_r <= 1'b0;
      mii_dv_r  <= 1'b0;
    end else if (ce) begin
      if (!rmii_mode) begin
        mii_crs_r <= crs;
        mii_dv_r  <= rx_dv;
        crs_dv_r  <= 1'b0;
      end else begin
        mii_crs_r <= 1'b0;
        mii_dv_r  <= 1'b0;
        if (old_rev) crs_dv_r <= crs | rx_dv;
        else if (crs) crs_dv_r <= 1'b1;
        else if (rx_dv) crs_dv_r <= ~crs_dv_r;
        else crs_dv_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_bypass;
    ce && !rmii_mode |=> !crs_dv_r && mii_crs_r == $past(crs);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("reduced logic not bypassed");
  property p_old_rev;
    ce && rmii_mode && old_rev && rx_dv |=> crs_dv_r;
  endproperty
  a_old_rev: assert property (p_old_rev)
    else $error("crs_dv dropped before data end");
  property p_toggle;
    ce && rmii_mode && !old_rev && !crs && rx_dv
      |=> crs_dv_r != $past(crs_dv_r);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("crs_dv did not toggle");
  c_toggle: cover property (ce && rmii_mode && !old_rev && !crs && rx_dv);
endmodule
`default_nettype wire

// [verilog/pcs_rmii_config_regs.sv]
// Coding sublayer and reduced interface configuration register block
//
// Behaviour
// - Upper reserved bits of both registers ignore writes and read zero.
// - Bit 10 set selects true quiet transmit; clear is normal.
// - Bit 9 set forces signal detect; clear is normal detection.
// - Algorithm bit 1: link after signal and lock, held while signal valid.
// - Algorithm bit 0: link held only while signal valid and locked.
// - Descrambler timeout is 2 ms with bit 7 set, else 722 us.
// - Bit 5 set forces a good 100 Mb/s link indication.
// - Bit 2 set bypasses NRZI encoding and decoding.
// - Interface select resets to 0, then loads the strap after reset release; writable; 0 MII, 1 reduced.
// - Without reduced mode, reduced-interface logic has no effect.
// - Revision bit 0: CRS_DV toggles at packet end after carrier drops.
// - Revision bit 1: CRS_DV stays high until last data, no toggle.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_rmii_defs.svh"
module pcs_rmii_config_regs
  import pcs_rmii_pkg::*;
#(
  parameter int DESC_SHORT_CYC = `DESC_SHORT_NS / `CLK_NS,
  parameter int DESC_LONG_CYC  = `DESC_LONG_NS / `CLK_NS
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [9:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Pins
  input  wire logic        signal_level_pin,
  input  wire logic        rmii_strap_pin,
  // Receive path status
  input  wire logic        descr_ok,
  input  wire logic        crs_in,
  input  wire logic        rx_dv_in,
  // Coding sublayer controls and link status
  output logic             true_quiet_enable,
  output logic             nrzi_bypass,
  output logic             free_clk,
  output logic             link_ok,
  output logic             descr_locked,
  // Data interface
  output logic             rmii_mode,
  output logic             crs_dv,
  output logic             mii_crs,
  output logic             mii_rx_dv
);
  localparam logic [9:0] PCS_ADDR = {`PCS_CFG_IDX, 2'b00};
  localparam logic [9:0] RIB_ADDR = {`RIB_IDX, 2'b00};

  logic [15:0] pcs_config_status_r;
  logic [15:0] reduced_interface_bypass_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_nxt;
  logic        waitrequest_r;
  logic        accept;
  logic        sig_s1_r;
  logic        sig_s2_r;
  logic        strap_s1_r;
  logic        strap_s2_r;
  logic [1:0]  strap_cnt_r;
  pcs_ctrl_s   ctrl;

  // Pin synchronisers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sig_s1_r   <= 1'b0;
      sig_s2_r   <= 1'b0;
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else if (ce) begin
      sig_s1_r   <= signal_level_pin;
      sig_s2_r   <= sig_s1_r;
      strap_s1_r <= rmii_strap_pin;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Strap capture counter after reset release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_cnt_r <= 2'h0;
    end else if (ce && strap_cnt_r != `STRAP_DONE_CNT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
    end
  end

  // Bus handshake: one wait cycle, then accept
  assign accept = (read | write) & ~waitrequest_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest_r <= 1'b1;
    end else if (ce) begin
      if (accept) waitrequest_r <= 1'b1;
      else if (read | write) waitrequest_r <= 1'b0;
    end
  end

  // Read data mux
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (address == PCS_ADDR) begin
      rd_nxt[15:0] = pcs_config_status_r & `PCS_WMASK;
    end else if (address == RIB_ADDR) begin
      rd_nxt[15:0] = reduced_interface_bypass_r & `RIB_WMASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readdata_r <= 32'h0000_0000;
    end else if (ce) begin
      if (read && waitrequest_r) readdata_r <= rd_nxt;
    end
  end

  // Coding sublayer register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pcs_config_status_r <= `PCS_RST;
    end else if (ce && accept && write && address == PCS_ADDR) begin
      pcs_config_status_r <= writedata[15:0] & `PCS_WMASK;
    end
  end

  // Reduced interface register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reduced_interface_bypass_r <= `RIB_RST;
    end else if (ce) begin
      if (accept && write && address == RIB_ADDR) begin
        reduced_interface_bypass_r <= writedata[15:0] & `RIB_WMASK;
      end else if (strap_cnt_r == `STRAP_LOAD_CNT) begin
        reduced_interface_bypass_r[`RMODE_BIT] <= strap_s2_r;
      end
    end
  end

  assign ctrl.true_quiet    = pcs_config_status_r[`TQ_BIT];
  assign ctrl.force_sd      = pcs_config_status_r[`FSD_BIT];
  assign ctrl.sd_alg        = pcs_config_status_r[`SDALG_BIT];
  assign ctrl.descrambler_timeout_select_sel = pcs_config_status_r[`DTS_BIT];
  assign ctrl.force_100_ok  = pcs_config_status_r[`F100_BIT];
  assign ctrl.nrzi_bypass   = pcs_config_status_r[`NRZI_BIT];

  assign readdata          = readdata_r;
  assign waitrequest       = waitrequest_r;
  assign true_quiet_enable = pcs_config_status_r[`TQ_BIT];
  assign nrzi_bypass       = pcs_config_status_r[`NRZI_BIT];
  assign free_clk          = pcs_config_status_r[`FREE_CLK_BIT];
  assign rmii_mode         = reduced_interface_bypass_r[`RMODE_BIT];

  link_monitor #(
    .SHORT_CYC (DESC_SHORT_CYC),
    .LONG_CYC  (DESC_LONG_CYC)
  ) u_link (
    .clk          (clk),
    .reset        (reset),
    .ce           (ce),
    .ctrl         (ctrl),
    .signal_level (sig_s2_r),
    .descr_ok     (descr_ok),
    .link_up_r    (link_ok),
    .locked_r     (descr_locked)
  );

  crs_dv_gen u_crs (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .rmii_mode (reduced_interface_bypass_r[`RMODE_BIT]),
    .old_rev   (reduced_interface_bypass_r[`OLDREV_BIT]),
    .crs       (crs_in),
    .rx_dv     (rx_dv_in),
    .crs_dv_r  (crs_dv),
    .mii_crs_r (mii_crs),
    .mii_dv_r  (mii_rx_dv)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_rsvd_zero;
    ce && read && !waitrequest_r && address == PCS_ADDR
      |-> readdata_r[31:12] == 20'h00000 && readdata_r[6] == 1'b0
        && readdata_r[4:3] == 2'b00 && readdata_r[1:0] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");
  property p_tq_write;
    ce && accept && write && address == PCS_ADDR
      |=> true_quiet_enable == $past(writedata[`TQ_BIT]);
  endproperty
  a_tq_write: assert property (p_tq_write)
    else $error("true quiet bit not written");
  property p_nrzi_write;
    ce && accept && write && address == PCS_ADDR
      |=> nrzi_bypass == $past(writedata[`NRZI_BIT]);
  endproperty
  a_nrzi_write: assert property (p_nrzi_write)
    else $error("nrzi bypass bit not written");
  property p_strap;
    ce && strap_cnt_r == `STRAP_LOAD_CNT && !(accept && write)
      |=> rmii_mode == $past(strap_s2_r);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not captured");
  property p_wait;
    ce && (read | write) && waitrequest_r |=> !waitrequest_r;
  endproperty
  a_wait: assert property (p_wait)
    else $error("slave did not answer");

  property p_rib_rsvd_zero;
    ce && read && !waitrequest_r && address == RIB_ADDR
      |-> readdata_r[31:6] == 26'h0000000
        && readdata_r[3:0] == 4'h0;
  endproperty
  a_rib_rsvd_zero: assert property (p_rib_rsvd_zero)
    else $error("reduced register reserved bits nonzero");
  property p_unmapped_zero;
    ce && read && waitrequest_r
      && address != PCS_ADDR && address != RIB_ADDR
      |=> readdata_r == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read nonzero");
  property p_read_capture;
    ce && read && waitrequest_r |=> readdata_r == $past(rd_nxt);
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("read data not captured");
  property p_pcs_unmapped_write;
    ce && accept && write && address != PCS_ADDR
      |=> $stable(pcs_config_status_r);
  endproperty
  a_pcs_unmapped_write: assert property (p_pcs_unmapped_write)
    else $error("coding register changed by other write");
  property p_pcs_rsvd_store;
    ce |=> (pcs_config_status_r & ~`PCS_WMASK) == 16'h0000;
  endproperty
  a_pcs_rsvd_store: assert property (p_pcs_rsvd_store)
    else $error("reserved coding bit stored");
  property p_sd_alg_write;
    ce && accept && write && address == PCS_ADDR
      |=> pcs_config_status_r[`SDALG_BIT] == $past(writedata[`SDALG_BIT]);
  endproperty
  a_sd_alg_write: assert property (p_sd_alg_write)
    else $error("algorithm bit not written");
  property p_free_clk_write;
    ce && accept && write && address == PCS_ADDR
      |=> free_clk == $past(writedata[`FREE_CLK_BIT]);
  endproperty
  a_free_clk_write: assert property (p_free_clk_write)
    else $error("receive clock bit not written");

  property p_rib_write;
    ce && accept && write && address == RIB_ADDR
      |=> rmii_mode == $past(writedata[`RMODE_BIT]);
  endproperty
  a_rib_write: assert property (p_rib_write)
    else $error("interface select not written");
  property p_strap_hold;
    ce && strap_cnt_r == `STRAP_DONE_CNT && !(accept && write)
      |=> $stable(reduced_interface_bypass_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("reduced register moved without a write");
  property p_strap_count;
    ce && strap_cnt_r != `STRAP_DONE_CNT
      |=> strap_cnt_r == $past(strap_cnt_r) + 2'h1;
  endproperty
  a_strap_count: assert property (p_strap_count)
    else $error("strap counter did not advance");

  property p_wait_one;
    ce && !waitrequest_r && (read | write) |=> waitrequest_r;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  property p_wait_idle;
    ce && !(read | write) && waitrequest_r |=> waitrequest_r;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest dropped without a request");
  property p_freeze;
    !ce |=> $stable(pcs_config_status_r)
      && $stable(reduced_interface_bypass_r)
      && $stable(waitrequest_r) && $stable(readdata_r);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with clock enable low");
  c_strap: cover property (ce && strap_cnt_r == `STRAP_LOAD_CNT);
  c_write: cover property (ce && accept && write);
  c_read: cover property (ce && accept && read && address == RIB_ADDR);
endmodule
`default_nettype wire

// [sim/rx_status_src.sv]
// Receive status source feeding carrier and data valid frames to the block
`timescale 1ns/10ps
`default_nettype none
module rx_status_src (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Frame request
  input  wire logic start,
  // Receive status
  output logic      crs,
  output logic      rx_dv
);
  logic [3:0] cnt_r;
  // Frame phase counter, eight cycles of data valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 4'h0;
    end else if (start) begin
      cnt_r <= 4'h1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
    end
  end
  // Carrier drops four cycles before the last data
  assign crs   = (cnt_r != 4'h0) && (cnt_r < 4'h5);
  assign rx_dv = (cnt_r != 4'h0);
endmodule
`default_nettype wire

// [sim/pcs_rmii_config_regs_tb.sv]
// Self-checking bench for the configuration register block
`timescale 1ns/10ps
`default_nettype none
`include "pcs_rmii_defs.svh"
module pcs_rmii_config_regs_tb;
  localparam logic [9:0] PCS_A = 10'h058;
  localparam logic [9:0] RIB_A = 10'h05c;
  logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic        sl = 1'b0, strap = 1'b1, dok = 1'b0, start = 1'b0;
  logic [9:0]  address = 10'h000;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic        waitrequest, tq, nb, link, lock, rmode, crs_dv, mcrs, mdv;
  logic        crs, rxdv;
  logic        ce = 1'b1, fc;
  int          failures = 0, checks = 0, ones, togs, ncrs, ndv;

  always #25 clk = ~clk;

  pcs_rmii_config_regs #(.DESC_SHORT_CYC(8), .DESC_LONG_CYC(16)) i_dut (
    .clk(clk), .reset(reset), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .signal_level_pin(sl),
    .rmii_strap_pin(strap), .descr_ok(dok), .crs_in(crs), .rx_dv_in(rxdv),
    .true_quiet_enable(tq), .nrzi_bypass(nb), .free_clk(fc),
    .descr_locked(lock), .rmii_mode(rmode), .crs_dv(crs_dv), .link_ok(link),
    .mii_crs(mcrs), .mii_rx_dv(mdv));

  rx_status_src i_src (
    .clk(clk), .reset(reset), .start(start), .crs(crs), .rx_dv(rxdv));

  task finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("mismatch at %0t: bus timeout", $time);
      finish_test;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [9:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(q, exp, m);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sets the signal level pin and gives one descrambler pulse
  task stim(input logic s);
    @(posedge clk);
    sl <= s;
    dok <= 1'b1;
    @(posedge clk);
    dok <= 1'b0;
  endtask

  // Sends one frame and counts what the data interface shows
  task run_frame;
    logic prev;
    ones = 0;
    togs = 0;
    ncrs = 0;
    ndv = 0;
    prev = 1'b0;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (14) begin
      cyc(1);
      ones += (crs_dv === 1'b1);
      togs += (crs_dv !== prev);
      ncrs += (mcrs === 1'b1);
      ndv += (mdv === 1'b1);
      prev = crs_dv;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: run timeout", $time);
    finish_test;
  end

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    cyc(4);
    chk(rmode, 1'b1, "strap mode");
    rd(PCS_A, `PCS_RST, "pcs reset value");
    rd(RIB_A, 32'h20, "reduced reset value");
    rd(10'h060, 32'h0, "unmapped read");
    wr(PCS_A, 32'hffff_efa4);
    rd(PCS_A, `PCS_WMASK, "pcs writable bits");
    cyc(1);
    chk(tq, 1'b1, "true quiet on");
    chk(nb, 1'b1, "nrzi bypass on");
    chk(fc, 1'b1, "receive clock bit on");
    wr(PCS_A, `PCS_RST);
    cyc(1);
    chk(tq, 1'b0, "true quiet off");
    chk(nb, 1'b0, "nrzi bypass off");
    chk(fc, 1'b0, "receive clock bit off");
    wr(RIB_A, 32'hffff_ffff);
    rd(RIB_A, `RIB_WMASK, "reduced writable bits");
    $display("test registers done");
    stim(1'b1);
    cyc(6);
    chk(link, 1'b1, "link up default");
    cyc(12);
    chk(lock, 1'b0, "short timeout");
    chk(link, 1'b1, "link held unlocked");
    stim(1'b0);
    cyc(6);
    chk(link, 1'b0, "link drops on level");
    wr(PCS_A, 32'h0);
    stim(1'b1);
    cyc(6);
    chk(link, 1'b1, "link up modified");
    cyc(12);
    chk(link, 1'b0, "link drops on lock");
    wr(PCS_A, 32'h80);
    stim(1'b1);
    cyc(12);
    chk(lock, 1'b1, "long timeout running");
    cyc(10);
    chk(lock, 1'b0, "long timeout over");
    wr(PCS_A, 32'h300);
    stim(1'b0);
    cyc(6);
    chk(link, 1'b1, "forced signal detect");
    wr(PCS_A, 32'h100);
    cyc(4);
    chk(link, 1'b0, "link down unforced");
    wr(PCS_A, 32'h20);
    cyc(2);
    chk(link, 1'b1, "forced good link");
    @(posedge clk);
    ce <= 1'b0;
    stim(1'b1);
    cyc(3);
    chk(lock, 1'b0, "frozen lock");
    chk(link, 1'b1, "frozen link");
    @(posedge clk);
    ce <= 1'b1;
    $display("test link done");
    run_frame;
    chk(ones, 8, "old revision high");
    chk(togs, 2, "old revision no toggle");
    wr(RIB_A, 32'h20);
    run_frame;
    chk(togs, 6, "new revision toggles");
    chk(ones, 6, "new revision high cycles");
    wr(RIB_A, 32'h0);
    cyc(1);
    chk(rmode, 1'b0, "mii mode");
    run_frame;
    chk(ones, 0, "no crs_dv in mii");
    chk(ncrs, 4, "mii carrier");
    chk(ndv, 8, "mii data valid");
    $display("test data interface done");
    finish_test;
  end
endmodule
`default_nettype wire
